// ---- pkg/dmrc_pkg.sv ----
// Constants shared by the mode-register configuration ends.
// Assumes a single 250 MHz clock shared by both ends.
package dmrc_pkg;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 3;
  // Bank codes selecting each mode register
  localparam logic [2:0] BANK_MR0 = 3'h0;
  localparam logic [2:0] BANK_MR1 = 3'h1;
  localparam logic [2:0] BANK_MR2 = 3'h2;
  localparam logic [2:0] BANK_MR3 = 3'h3;
  // Register one fields
  localparam int MR1_DLL_DIS = 0;
  localparam int MR1_AL_LO = 3;
  localparam int MR1_WLVL = 7;
  localparam int MR1_QOFF = 12;
  localparam int MR1_RTT0 = 2;
  localparam int MR1_RTT1 = 6;
  localparam int MR1_RTT2 = 9;
  // Register two fields
  localparam int MR2_PARTIAL_ARRAY_SELF_REFRESH_LO = 0;
  localparam int MR2_CWL_LO = 3;
  localparam int MR2_SRT = 7;
  localparam int MR2_RTTWR_LO = 9;
  localparam logic [12:0] MR2_RSVD_MASK = 13'h1940;
  // Register three fields
  localparam int MR3_LOC_LO = 0;
  localparam int MR3_MPR_EN = 2;
  localparam logic [12:0] MR3_RSVD_MASK = 13'h1ff8;
  // Latency encodings
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;
  localparam logic [4:0] AL_OFF1 = 5'h01;
  localparam logic [4:0] AL_OFF2 = 5'h02;
  // Nominal termination codes allowed in leveling: half, quarter, sixth
  localparam logic [2:0] RTT_DIV4 = 3'h1;
  localparam logic [2:0] RTT_DIV2 = 3'h2;
  localparam logic [2:0] RTT_DIV6 = 3'h3;
  localparam logic [1:0] RATE_1X = 2'h1;
  localparam logic [1:0] RATE_2X = 2'h2;
  localparam logic [7:0] MPR_PATTERN = 8'h55;
  // Refresh periods
  localparam int REF_PERIOD_NORM_MS = 64;
  localparam int REF_PERIOD_HOT_MS = 32;
  localparam int CLK_MHZ = 250;
  localparam int REF_CMDS = 8192;
  localparam int REFI_NORM_CYC = (REF_PERIOD_NORM_MS * 1000 * CLK_MHZ) / REF_CMDS;
  localparam int REFI_HOT_CYC = (REF_PERIOD_HOT_MS * 1000 * CLK_MHZ) / REF_CMDS;
  localparam int REFI_W = 12;
endpackage

// ---- pkg/dmrc_if.sv ----
// Command pins between memory controller and mode-register logic.
// Assumes both ends share clock_i.
`timescale 1ns/100ps
`default_nettype none
interface dmrc_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [12:0] addr;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr);
  modport mem (input cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface
`default_nettype wire

// ---- design/dmrc_latency.sv ----
// Total write latency from additive and CAS write latency settings.
// Assumes register fields already captured.
`timescale 1ns/100ps
`default_nettype none
module dmrc_latency (
  input wire logic [1:0] al_code_i,
  input wire logic [2:0] cwl_code_i,
  output logic [4:0] cas_write_latency_o,
  output logic [4:0] total_write_latency_o
);
  import dmrc_pkg::*;
  logic [4:0] additive_latency;
  logic [4:0] cas_latency;
  always_comb begin
    cas_write_latency_o = CWL_BASE + {2'h0, cwl_code_i};
    // Read latency is taken as one cycle above the write latency
    cas_latency = cas_write_latency_o + AL_OFF1;
    unique case (al_code_i)
      AL_CL1: additive_latency = cas_latency - AL_OFF1;
      AL_CL2: additive_latency = cas_latency - AL_OFF2;
      default: additive_latency = 5'h00;
    endcase
    total_write_latency_o = additive_latency + cas_write_latency_o;
  end
endmodule // dmrc_latency
`default_nettype wire

// ---- design/dmrc_mem.sv ----
// What this block does
// - Output-disable bit zeroes read_data_o and drops outputs_enabled_o
// - Bank two command loads register two
// - Controller zeroes reserved bits of register two
// - Partial self-refresh may lose out-of-range data
// - CAS write latency whole cycles, bits three-five
// - Write latency equals additive plus CAS
// - Bits nine, ten pick write termination
// - Leveling offers only nominal termination
// - Write termination applies without nominal termination
// - Temperature bit clear keeps 1x rate
// - Temperature bit set doubles self-refresh rate
// - Controller halves refresh period when hot
// - Hot: set temperature bit or avoid self-refresh
// - Bank three command loads register three
// - Controller zeroes reserved bits of register three
// - Normal mode ignores pattern location bits
// - Pattern register enabled returns fixed pattern
// - Controller should implement write leveling; this controller has no leveling sequence
// - Leveling bit; limited nominal terminations allowed
// - DLL off: controller zeroes write termination
// Memory-side end: mode registers one to three and their effects.
// Assumes command pins synchronous to clock_i.
`timescale 1ns/100ps
`default_nettype none
module dmrc_mem (
  input wire logic clock_i,
  input wire logic nrst_i,
  dmrc_if.mem cmd,
  input wire logic write_active_i,
  input wire logic self_refresh_i,
  input wire logic [7:0] read_data_i,
  output logic outputs_enabled_o,
  output logic [1:0] self_refresh_rate_o,
  output logic [2:0] partial_array_self_refresh_o,
  output logic [2:0] active_rtt_o,
  output logic rtt_nom_illegal_o,
  output logic [4:0] cas_write_latency_o,
  output logic [4:0] total_write_latency_o,
  output logic [7:0] read_data_o,
  output logic [12:0] mode_reg_one_o,
  output logic [12:0] mode_reg_two_o,
  output logic [12:0] mode_reg_three_o
);
  import dmrc_pkg::*;
  // Registers sit in flip-flops; reset leaves every field at zero
  logic [12:0] mode_reg_one_q, mode_reg_one_d;
  logic [12:0] mode_reg_two_q, mode_reg_two_d;
  logic [12:0] mode_reg_three_q, mode_reg_three_d;
  logic [7:0] rdata_q, rdata_d;
  logic mrs;
  logic leveling;
  logic output_off;
  logic sr_fast;
  logic [2:0] rtt_nom;
  logic [1:0] rtt_wr;
  logic wr_term_on;

  // Nominal termination code is spread over three bits of register one
  function automatic logic [2:0] rtt_nom_of(input logic [12:0] r);
    rtt_nom_of = {r[MR1_RTT2], r[MR1_RTT1], r[MR1_RTT0]};
  endfunction

  // Codes usable while leveling with outputs enabled: off, half, quarter, sixth
  function automatic logic rtt_ok_leveling(input logic [2:0] code);
    rtt_ok_leveling = code == 3'h0 || code == RTT_DIV2 || code == RTT_DIV4 || code == RTT_DIV6;
  endfunction

  // A full mode command on the pins aimed at one bank
  function automatic logic loads(input logic cmd_ok, input logic [2:0] ba, input logic [2:0] bank);
    loads = cmd_ok && ba == bank;
  endfunction

  // Reserved positions never reach a stored register
  function automatic logic [12:0] drop_reserved(input logic [12:0] v, input logic [12:0] mask);
    drop_reserved = v & ~mask;
  endfunction

  // Command decode: all four strobes low
  always_comb begin
    mrs = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
  end

  // Register one
  always_comb begin
    mode_reg_one_d = mode_reg_one_q;
    if (loads(mrs, cmd.ba, BANK_MR1)) begin
      mode_reg_one_d = cmd.addr;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg_one_q <= 13'h0000;
    end else begin
      mode_reg_one_q <= mode_reg_one_d;
    end
  end

  // Register two
  always_comb begin
    mode_reg_two_d = mode_reg_two_q;
    if (loads(mrs, cmd.ba, BANK_MR2)) begin
      mode_reg_two_d = drop_reserved(cmd.addr, MR2_RSVD_MASK);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg_two_q <= 13'h0000;
    end else begin
      mode_reg_two_q <= mode_reg_two_d;
    end
  end

  // Register three
  always_comb begin
    mode_reg_three_d = mode_reg_three_q;
    if (loads(mrs, cmd.ba, BANK_MR3)) begin
      mode_reg_three_d = drop_reserved(cmd.addr, MR3_RSVD_MASK);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg_three_q <= 13'h0000;
    end else begin
      mode_reg_three_q <= mode_reg_three_d;
    end
  end

  // Read path: pattern replaces array data; location bits are not looked at
  always_comb begin
    if (mode_reg_three_q[MR3_MPR_EN]) begin
      rdata_d = MPR_PATTERN;
    end else begin
      rdata_d = read_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Write-time termination only overrides during writes, never while leveling
  always_comb begin
    rtt_nom = rtt_nom_of(mode_reg_one_q);
    rtt_wr = mode_reg_two_q[MR2_RTTWR_LO +: 2];
    leveling = mode_reg_one_q[MR1_WLVL];
    wr_term_on = write_active_i && rtt_wr != 2'h0 && !leveling;
    if (leveling) begin
      active_rtt_o = rtt_nom;
    end else if (wr_term_on) begin
      active_rtt_o = {1'b0, rtt_wr};
    end else begin
      active_rtt_o = rtt_nom;
    end
    rtt_nom_illegal_o = leveling && !mode_reg_one_q[MR1_QOFF]
      && !rtt_ok_leveling(rtt_nom);
  end

  // Self-refresh effects
  always_comb begin
    sr_fast = mode_reg_two_q[MR2_SRT];
    if (sr_fast) begin
      self_refresh_rate_o = RATE_2X;
    end else begin
      self_refresh_rate_o = RATE_1X;
    end
    if (self_refresh_i) begin
      partial_array_self_refresh_o = mode_reg_two_q[MR2_PARTIAL_ARRAY_SELF_REFRESH_LO +: 3];
    end else begin
      partial_array_self_refresh_o = 3'h0;
    end
  end

  // Output disable gates the read path
  always_comb begin
    output_off = mode_reg_one_q[MR1_QOFF];
    outputs_enabled_o = !output_off;
    if (output_off) begin
      read_data_o = 8'h00;
    end else begin
      read_data_o = rdata_q;
    end
  end

  // Register mirrors
  always_comb begin
    mode_reg_one_o = mode_reg_one_q;
    mode_reg_two_o = mode_reg_two_q;
    mode_reg_three_o = mode_reg_three_q;
  end

  // Latency arithmetic lives in its own module
  dmrc_latency u_lat (
    .al_code_i(mode_reg_one_q[MR1_AL_LO +: 2]),
    .cwl_code_i(mode_reg_two_q[MR2_CWL_LO +: 3]),
    .cas_write_latency_o(cas_write_latency_o),
    .total_write_latency_o(total_write_latency_o)
  );
endmodule // dmrc_mem
`default_nettype wire

// ---- design/dmrc_ctrl.sv ----
// Controller-side end: issues mode register writes and paces refresh.
// Assumes the user holds a request until accepted.
`timescale 1ns/100ps
`default_nettype none
module dmrc_ctrl (
  input wire logic clock_i,
  input wire logic nrst_i,
  dmrc_if.ctrl cmd,
  input wire logic req_valid_i,
  input wire logic [1:0] req_reg_i,
  input wire logic [12:0] req_data_i,
  input wire logic hot_i,
  input wire logic dll_off_i,
  input wire logic want_self_refresh_i,
  output logic req_ready_o,
  output logic refresh_due_o,
  output logic self_refresh_ok_o,
  output logic [11:0] refresh_interval_o
);
  import dmrc_pkg::*;
  logic [12:0] addr_q, addr_d;
  logic [2:0] ba_q, ba_d;
  logic mrs_q, mrs_d;
  logic srt_q, srt_d;
  logic [REFI_W-1:0] cnt_q, cnt_d;
  logic due_q, due_d;
  logic [12:0] data;

  always_comb begin
    req_ready_o = 1'b1;
    data = req_data_i;
    mrs_d = req_valid_i && req_reg_i != 2'h0;
    ba_d = ba_q;
    addr_d = addr_q;
    srt_d = srt_q;
    if (mrs_d) begin
      unique case (req_reg_i)
        2'h1: begin
          ba_d = BANK_MR1;
        end
        2'h2: begin
          data = req_data_i & ~MR2_RSVD_MASK;
          if (dll_off_i) data[MR2_RTTWR_LO +: 2] = 2'h0;
          if (hot_i) data[MR2_SRT] = 1'b1;
          srt_d = data[MR2_SRT];
          ba_d = BANK_MR2;
        end
        default: begin
          data = req_data_i & ~MR3_RSVD_MASK;
          ba_d = BANK_MR3;
        end
      endcase
      addr_d = data;
    end
    refresh_interval_o = hot_i ? REFI_W'(REFI_HOT_CYC) : REFI_W'(REFI_NORM_CYC);
    due_d = cnt_q >= refresh_interval_o - 12'h001;
    cnt_d = due_d ? 12'h000 : cnt_q + 12'h001;
    self_refresh_ok_o = want_self_refresh_i && (!hot_i || srt_q);
    refresh_due_o = due_q;
    cmd.cs_n = !mrs_q;
    cmd.ras_n = !mrs_q;
    cmd.cas_n = !mrs_q;
    cmd.we_n = !mrs_q;
    cmd.ba = ba_q;
    cmd.addr = addr_q;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_q <= 13'h0000;
      ba_q <= 3'h0;
      mrs_q <= 1'b0;
      srt_q <= 1'b0;
      cnt_q <= 12'h000;
      due_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      ba_q <= ba_d;
      mrs_q <= mrs_d;
      srt_q <= srt_d;
      cnt_q <= cnt_d;
      due_q <= due_d;
    end
  end
endmodule // dmrc_ctrl
`default_nettype wire

// ---- dv/dmrc_checker.sv ----
// Checker on the command pins between the two ends.
// Assumes the test top feeds it the pins and the controller inputs.
`timescale 1ns/100ps
`default_nettype none
module dmrc_checker (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [12:0] addr,
  input wire logic req_valid_i,
  input wire logic [1:0] req_reg_i,
  input wire logic [12:0] req_data_i,
  input wire logic hot_i,
  input wire logic dll_off_i
);
  import dmrc_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_req_to_cmd: assert property (req_valid_i && req_reg_i != 2'h0 |=> !cs_n && ba == {1'b0, $past(req_reg_i)})
    else $error("request not issued next cycle");
  a_no_req_idle: assert property (!(req_valid_i && req_reg_i != 2'h0) |=> cs_n)
    else $error("command without request");
  a_cmd_all_low: assert property (!cs_n |-> !ras_n && !cas_n && !we_n)
    else $error("select without full mode command");
  a_ba2_low: assert property (!cs_n |-> !ba[2])
    else $error("bank bit two set");
  a_two_rsvd_zero: assert property (!cs_n && ba == BANK_MR2 |-> (addr & MR2_RSVD_MASK) == 13'h0)
    else $error("reserved bits of register two set");
  a_three_rsvd_zero: assert property (!cs_n && ba == BANK_MR3 |-> (addr & MR3_RSVD_MASK) == 13'h0)
    else $error("reserved bits of register three set");
  a_dll_off_rtt: assert property (!cs_n && ba == BANK_MR2 && $past(dll_off_i) |-> addr[10:9] == 2'h0)
    else $error("write termination set with loop off");
  a_hot_temp_bit: assert property (!cs_n && ba == BANK_MR2 && $past(hot_i) |-> addr[MR2_SRT])
    else $error("hot write without temperature bit");
  a_three_data: assert property (req_valid_i && req_reg_i == 2'h3 |=> addr == ($past(req_data_i) & ~MR3_RSVD_MASK))
    else $error("register three data wrong on pins");
endmodule // dmrc_checker
`default_nettype wire

// ---- dv/dram_mode_reg_config_test.sv ----
// Self-checking test joining controller and memory ends.
// Assumes package, interface, design and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module dram_mode_reg_config_test;
  import dmrc_pkg::*;
  logic clock_i, nrst_i, rv, hot, dll, wa, sr, want, oe, ill, sok, due, rdy;
  int gap;
  logic [1:0] rr, rate;
  logic [2:0] partial_array_self_refresh, artt;
  logic [4:0] cas_write_latency, wl;
  logic [7:0] rdi, rdo;
  logic [11:0] refi;
  logic [12:0] rd, m1, m2, m3;
  int err_count = 0;
  int n_compared = 0;
  dmrc_if bus();
  dmrc_ctrl u_dmrc_ctrl (.clock_i(clock_i), .nrst_i(nrst_i), .cmd(bus), .req_valid_i(rv), .req_reg_i(rr),
    .req_data_i(rd), .hot_i(hot), .dll_off_i(dll), .want_self_refresh_i(want), .req_ready_o(rdy),
    .refresh_due_o(due), .self_refresh_ok_o(sok), .refresh_interval_o(refi));
  dmrc_mem u_dmrc_mem (.clock_i(clock_i), .nrst_i(nrst_i), .cmd(bus), .write_active_i(wa), .self_refresh_i(sr),
    .read_data_i(rdi), .outputs_enabled_o(oe), .self_refresh_rate_o(rate), .partial_array_self_refresh_o(partial_array_self_refresh),
    .active_rtt_o(artt), .rtt_nom_illegal_o(ill), .cas_write_latency_o(cas_write_latency), .total_write_latency_o(wl),
    .read_data_o(rdo), .mode_reg_one_o(m1), .mode_reg_two_o(m2), .mode_reg_three_o(m3));
  dmrc_checker u_dmrc_checker (.clock_i(clock_i), .nrst_i(nrst_i), .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
    .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr), .req_valid_i(rv), .req_reg_i(rr), .req_data_i(rd),
    .hot_i(hot), .dll_off_i(dll));
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One request, then wait for pins and capture to land
  task automatic wr(input logic [1:0] r, input logic [12:0] d);
    @(negedge clock_i);
    rv = 1'b1;
    rr = r;
    rd = d;
    @(negedge clock_i);
    rv = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask
  // Cycles from one refresh pulse to the next
  task automatic due_gap(output int n);
    n = 0;
    while (!due) @(negedge clock_i);
    @(negedge clock_i);
    n = 1;
    while (!due) begin
      @(negedge clock_i);
      n++;
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Time limit of 15000 cycles, nearly eight normal refresh intervals
  initial begin
    #60000;
    err_count++;
    print_verdict();
  end
  initial begin
    nrst_i = 1'b0;
    {rv, hot, dll, wa, sr, want, rr, rd} = '0;
    rdi = 8'ha3;
    repeat (6) @(negedge clock_i);
    nrst_i = 1'b1;
    chk(m2, 13'h0);
    chk(13'(rdy), 13'h1);
    wr(2'h1, 13'h1000);
    chk(13'(oe), 13'h0);
    chk(13'(rdo), 13'h0);
    wr(2'h0, 13'h0);
    chk(m1, 13'h1000);
    wr(2'h2, 13'h1fff);
    chk(m2, 13'h06bf);
    for (int a = 0; a < 3; a++) begin
      for (int c = 0; c < 8; c++) begin
        wr(2'h1, 13'(a << MR1_AL_LO));
        wr(2'h2, 13'(c << MR2_CWL_LO));
        chk(13'(cas_write_latency), 13'(c + 5));
        chk(13'(wl), 13'(c + 5 + (a == 1 ? c + 5 : (a == 2 ? c + 4 : 0))));
      end
    end
    chk(13'(oe), 13'h1);
    sr = 1'b1;
    wr(2'h2, 13'h0005);
    chk(13'(partial_array_self_refresh), 13'h5);
    chk(13'(rate), 13'(RATE_1X));
    sr = 1'b0;
    @(negedge clock_i);
    chk(13'(partial_array_self_refresh), 13'h0);
    sr = 1'b1;
    wr(2'h2, 13'h0080);
    chk(13'(rate), 13'(RATE_2X));
    sr = 1'b0;
    chk(13'(refi), 13'(REFI_NORM_CYC));
    due_gap(gap);
    chk(13'(gap), 13'(REFI_NORM_CYC));
    hot = 1'b1;
    want = 1'b1;
    wr(2'h2, 13'h0);
    chk(m2, 13'h0080);
    chk(13'(refi), 13'(REFI_HOT_CYC));
    chk(13'(sok), 13'h1);
    hot = 1'b0;
    dll = 1'b1;
    wr(2'h2, 13'h0600);
    chk(m2, 13'h0);
    dll = 1'b0;
    wr(2'h2, 13'h0200);
    wr(2'h1, 13'h0280);
    chk(13'(ill), 13'h1);
    wr(2'h1, 13'h0084);
    chk(13'(ill), 13'h0);
    wa = 1'b1;
    @(negedge clock_i);
    chk(13'(artt), 13'h1);
    wr(2'h1, 13'h0);
    chk(13'(artt), 13'h1);
    wa = 1'b0;
    wr(2'h3, 13'h1fff);
    chk(m3, 13'h0007);
    chk(13'(rdo), 13'(MPR_PATTERN));
    wr(2'h3, 13'h0003);
    chk(13'(rdo), 13'(rdi));
    print_verdict();
  end
endmodule // dram_mode_reg_config_test
`default_nettype wire
